/* src/rstc_pkg.sv */
package rstc_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] RSTC_IDX_SOURCE = 8'h17;
  localparam logic [7:0] RSTC_IDX_THRESH = 8'h18;
  localparam logic [7:0] RSTC_ADDR_SOURCE = 8'h5c;
  localparam logic [7:0] RSTC_ADDR_THRESH = 8'h60;
  // reset values
  localparam logic [7:0] RSTC_RST_SOURCE = 8'h84;
  localparam logic [7:0] RSTC_RST_THRESH = 8'h84;
  // source register fields
  localparam int RSTC_SRC_SEL_LSB = 6;
  localparam int RSTC_SRC_SEL_W = 2;
  localparam int RSTC_GUARD_LSB = 0;
  localparam int RSTC_GUARD_W = 6;
  // threshold register fields
  localparam int RSTC_MIN_LSB = 4;
  localparam int RSTC_MIN_W = 4;
  localparam int RSTC_RSVD_BIT = 3;
  localparam int RSTC_COLL_LSB = 0;
  localparam int RSTC_COLL_W = 3;
  // command code that listens without the guard delay
  localparam logic [3:0] RSTC_CMD_RECEIVE = 4'h8;
  // avalon response codes
  localparam logic [1:0] RSTC_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSTC_RESP_SLVERR = 2'h2;
  // uart input sources
  typedef enum logic [1:0] {
    RSTC_SRC_LOW = 2'h0,
    RSTC_SRC_SIG_ENV = 2'h1,
    RSTC_SRC_ANALOG = 2'h2,
    RSTC_SRC_SIG_MOD = 2'h3
  } rstc_src_t;
endpackage : rstc_pkg

/* src/rstc_top.sv */
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
// Operation
// - source register resets to 84h; bits 7:6 source select, bits 5:0 guard delay.
// - select 00 drives uart input low; 01 takes envelope from secure-module pin.
// - select 10 takes the internal analog demodulator's modulation signal.
// - select 11 takes modulation from secure-module pin; software uses it above 424 kbit.
// - after transmission the receiver stays off for guard-delay bit clocks.
// - while the guard delay counts, antenna receive activity never reaches the decoder.
// - plain receive command skips the guard delay; all other commands apply it.
// - in passive mode counting starts at the last transmitted modulation pulse.
// - in active mode counting starts once the external rf field is on.
// - threshold register resets to 84h; 7:4 min level, 3 reserved, 2:0 collision.
// - decoder ignores inputs whose strength is below the minimum level.
// - collision flagged only when weaker half-bit reaches collision level of stronger.
// - threshold bit 3 reads zero; software writes it as zero.
module rstc_top #(
  parameter int GUARD_W = 6,
  parameter int STRENGTH_W = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  // avalon-mm slave, byte addressed
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic [1:0] avsResponse,
  output logic avsWaitRequest,
  // command and link events
  input wire logic cmdStart,
  input wire logic [3:0] cmdCode,
  input wire logic cmdStop,
  input wire logic activeMode,
  input wire logic bitClkTick,
  input wire logic txLastModPulse,
  input wire logic rfFieldOn,
  // receive sources
  input wire logic secureModuleInputPin,
  input wire logic analogModulation,
  input wire logic antennaRxPin,
  // decoder strength measures
  input wire logic [STRENGTH_W-1:0] decodeStrength,
  input wire logic [STRENGTH_W-1:0] halfBitStrong,
  input wire logic [STRENGTH_W-1:0] halfBitWeak,
  // outputs
  output logic uartInput,
  output logic sigInIsModulation,
  output logic rxEnable,
  output logic rxDecoderData,
  output logic decodeValid,
  output logic bitCollision
);
  import rstc_pkg::*;

  initial begin
    if (GUARD_W != RSTC_GUARD_W) $error("guard width must match the register field");
    if (STRENGTH_W < RSTC_MIN_W) $error("strength width below the min level field");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  typedef enum {
    RSTC_ST_IDLE,
    RSTC_ST_ARMED,
    RSTC_ST_GUARD,
    RSTC_ST_LISTEN
  } rstc_state_t;

  logic [7:0] srcReg_q, srcReg_d;
  logic [7:0] thrReg_q, thrReg_d;
  logic ack_q, ack_d;
  logic [31:0] rdData_q, rdData_d;
  logic [1:0] resp_q, resp_d;

  // address decode shared by read mux and write strobes
  function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] base);
    addrHit = (addr == base);
  endfunction : addrHit

  wire request = avsRead | avsWrite;
  wire takeNow = request & ~ack_q; // first cycle; answer in the next
  wire hitSrc = addrHit(avsAddress, RSTC_ADDR_SOURCE);
  wire hitThr = addrHit(avsAddress, RSTC_ADDR_THRESH);
  wire mapped = hitSrc | hitThr;
  wire wrLane0 = takeNow & avsWrite & avsByteEnable[0];
  wire [7:0] thrWrite = {avsWriteData[7:4], 1'b0, avsWriteData[2:0]};
  wire [7:0] rdMux = hitSrc ? srcReg_q : (hitThr ? thrReg_q : 8'h00);

  assign ack_d = takeNow;
  assign srcReg_d = (wrLane0 & hitSrc) ? avsWriteData[7:0] : srcReg_q;
  assign thrReg_d = (wrLane0 & hitThr) ? thrWrite : thrReg_q;
  assign rdData_d = (takeNow & avsRead) ? {24'h000000, rdMux} : rdData_q;
  assign resp_d = takeNow ? (mapped ? RSTC_RESP_OKAY : RSTC_RESP_SLVERR) : resp_q;
  assign avsWaitRequest = request & ~ack_q;
  assign avsReadData = rdData_q;
  assign avsResponse = resp_q;

  // register storage and bus answer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      srcReg_q <= RSTC_RST_SOURCE;
      thrReg_q <= RSTC_RST_THRESH;
      ack_q <= 1'b0;
      rdData_q <= 32'h00000000;
      resp_q <= RSTC_RESP_OKAY;
    end else begin
      srcReg_q <= srcReg_d;
      thrReg_q <= thrReg_d;
      ack_q <= ack_d;
      rdData_q <= rdData_d;
      resp_q <= resp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field extraction

  wire [1:0] srcSel = srcReg_q[RSTC_SRC_SEL_LSB +: RSTC_SRC_SEL_W];
  wire [GUARD_W-1:0] guardDelay = srcReg_q[RSTC_GUARD_LSB +: GUARD_W];
  wire [RSTC_MIN_W-1:0] decode_min_strength = thrReg_q[RSTC_MIN_LSB +: RSTC_MIN_W];
  wire [RSTC_COLL_W-1:0] collision_threshold = thrReg_q[RSTC_COLL_LSB +: RSTC_COLL_W];

  ////////////////////////////////////////////////////////////////////////////
  // uart input source select

  logic uartIn_q, uartIn_d;
  logic sigMod_q;
  wire srcIsLow = (srcSel == RSTC_SRC_LOW);
  wire srcIsAnalog = (srcSel == RSTC_SRC_ANALOG);
  wire srcIsSigMod = (srcSel == RSTC_SRC_SIG_MOD);

  // 01 and 11 both read the secure-module pin; 11 marks it as modulation
  assign uartIn_d = srcIsLow ? 1'b0 :
                    srcIsAnalog ? analogModulation :
                    secureModuleInputPin;
  assign uartInput = uartIn_q;
  assign sigInIsModulation = sigMod_q;

  // registered source
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      uartIn_q <= 1'b0;
      sigMod_q <= 1'b0;
    end else begin
      uartIn_q <= uartIn_d;
      sigMod_q <= srcIsSigMod;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver guard sequencer

  rstc_state_t state_q, state_d;
  logic [GUARD_W-1:0] guardCnt_q, guardCnt_d;

  wire plainReceive = cmdStart & (cmdCode == RSTC_CMD_RECEIVE);
  wire guardedCmd = cmdStart & (cmdCode != RSTC_CMD_RECEIVE);
  wire startCond = activeMode ? rfFieldOn : txLastModPulse;
  wire guardZero = (guardDelay == '0);
  wire lastTick = bitClkTick & (guardCnt_q == GUARD_W'(1));

  // next state; a stop wins, a new command restarts the sequence
  always_comb begin
    state_d = state_q;
    guardCnt_d = guardCnt_q;
    if (cmdStop) begin
      state_d = RSTC_ST_IDLE;
      guardCnt_d = '0;
    end else if (plainReceive) begin
      state_d = RSTC_ST_LISTEN;
      guardCnt_d = '0;
    end else if (guardedCmd) begin
      state_d = RSTC_ST_ARMED;
      guardCnt_d = '0;
    end else begin
      unique case (state_q)
        RSTC_ST_IDLE: begin
          state_d = RSTC_ST_IDLE;
        end
        RSTC_ST_ARMED: begin
          if (startCond) begin
            guardCnt_d = guardDelay;
            state_d = guardZero ? RSTC_ST_LISTEN : RSTC_ST_GUARD;
          end
        end
        RSTC_ST_GUARD: begin
          if (bitClkTick) begin
            guardCnt_d = guardCnt_q - GUARD_W'(1);
          end
          if (lastTick) begin
            state_d = RSTC_ST_LISTEN;
          end
        end
        RSTC_ST_LISTEN: begin
          state_d = RSTC_ST_LISTEN;
        end
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= RSTC_ST_IDLE;
      guardCnt_q <= '0;
    end else begin
      state_q <= state_d;
      guardCnt_q <= guardCnt_d;
    end
  end

  assign rxEnable = (state_q == RSTC_ST_LISTEN);

  ////////////////////////////////////////////////////////////////////////////
  // decoder gating and thresholds

  logic rxData_q, valid_q, coll_q;
  wire [STRENGTH_W-1:0] minScaled = STRENGTH_W'(decode_min_strength);
  wire strongEnough = (decodeStrength >= minScaled);
  // weak * 8 >= strong * level, i.e. weak reaches level/8 of strong
  wire [STRENGTH_W+3:0] weakScaled = {halfBitWeak, 3'h0};
  wire [STRENGTH_W+3:0] strongScaled = (STRENGTH_W + 4)'(halfBitStrong * collision_threshold);
  wire collHit = (weakScaled >= strongScaled);

  assign rxDecoderData = rxData_q;
  assign decodeValid = valid_q;
  assign bitCollision = coll_q;

  // antenna data reaches the decoder only once listening
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rxData_q <= 1'b0;
      valid_q <= 1'b0;
      coll_q <= 1'b0;
    end else begin
      rxData_q <= rxEnable & antennaRxPin;
      valid_q <= rxEnable & strongEnough;
      coll_q <= rxEnable & strongEnough & collHit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  reset_value_a: assert property (@(posedge mclk) $rose(nrst) |->
    srcReg_q == RSTC_RST_SOURCE && thrReg_q == RSTC_RST_THRESH)
    else $error("config registers not at reset value");

  src_low_a: assert property (@(posedge mclk) disable iff (!nrst)
    (srcSel == RSTC_SRC_LOW && $stable(srcSel)) |=> !uartInput)
    else $error("uart input not low for source 00");

  src_analog_a: assert property (@(posedge mclk) disable iff (!nrst)
    (srcSel == RSTC_SRC_ANALOG) |=> uartInput == $past(analogModulation))
    else $error("uart input not from analog path");

  src_sigmod_a: assert property (@(posedge mclk) disable iff (!nrst)
    (srcSel == RSTC_SRC_SIG_MOD) |=> uartInput == $past(secureModuleInputPin)
    && sigInIsModulation)
    else $error("uart input not from secure-module pin");

  guard_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
    !rxEnable |=> !rxDecoderData && !decodeValid)
    else $error("decoder saw data while receiver off");

  guard_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_q == RSTC_ST_GUARD && !lastTick && !cmdStop && !cmdStart) |=> !rxEnable)
    else $error("receiver enabled before guard expired");

  recv_skip_a: assert property (@(posedge mclk) disable iff (!nrst)
    (plainReceive && !cmdStop) |=> rxEnable)
    else $error("receive command did not listen at once");

  start_load_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_q == RSTC_ST_ARMED && startCond && !cmdStart && !cmdStop && !guardZero)
    |=> state_q == RSTC_ST_GUARD && guardCnt_q == $past(guardDelay))
    else $error("guard counter not loaded on start condition");

  guard_expire_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_q == RSTC_ST_GUARD && lastTick && !cmdStart && !cmdStop) |=> rxEnable)
    else $error("receiver not enabled on guard expiry");

  rsvd_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
    thrReg_q[RSTC_RSVD_BIT] == 1'b0)
    else $error("reserved threshold bit not zero");

  weak_ignore_a: assert property (@(posedge mclk) disable iff (!nrst)
    !strongEnough |=> !decodeValid && !bitCollision)
    else $error("weak input evaluated by decoder");

  wait_one_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(request) |=> !avsWaitRequest)
    else $error("bus answer not after one wait cycle");

  data_pass_a: assert property (@(posedge mclk) disable iff (!nrst)
    rxEnable |=> rxDecoderData == $past(antennaRxPin))
    else $error("antenna data not passed while listening");

  min_accept_a: assert property (@(posedge mclk) disable iff (!nrst)
    (rxEnable && strongEnough) |=> decodeValid)
    else $error("strong input not evaluated");

  coll_flag_a: assert property (@(posedge mclk) disable iff (!nrst)
    (rxEnable && strongEnough && collHit) |=> bitCollision)
    else $error("collision not flagged at level");

  coll_quiet_a: assert property (@(posedge mclk) disable iff (!nrst)
    !collHit |=> !bitCollision)
    else $error("collision flagged below level");

  stop_off_a: assert property (@(posedge mclk) disable iff (!nrst)
    cmdStop |=> !rxEnable)
    else $error("receiver still on after stop");

  guarded_arm_a: assert property (@(posedge mclk) disable iff (!nrst)
    (guardedCmd && !cmdStop) |=> !rxEnable)
    else $error("guarded command listened at once");

  zero_guard_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_q == RSTC_ST_ARMED && startCond && !cmdStart && !cmdStop && guardZero)
    |=> rxEnable)
    else $error("zero guard did not listen at once");

  bad_addr_a: assert property (@(posedge mclk) disable iff (!nrst)
    (request && !ack_q && !mapped) |=> avsResponse == RSTC_RESP_SLVERR)
    else $error("unmapped access not refused");

  thr_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    (wrLane0 && hitThr) |=> thrReg_q == $past(thrWrite))
    else $error("threshold write not stored");

  guard_seen_c: cover property (@(posedge mclk) disable iff (!nrst)
    state_q == RSTC_ST_GUARD ##[1:100] rxEnable);
  active_start_c: cover property (@(posedge mclk) disable iff (!nrst)
    state_q == RSTC_ST_ARMED && activeMode && rfFieldOn);
  collision_c: cover property (@(posedge mclk) disable iff (!nrst) bitCollision);
  plain_recv_c: cover property (@(posedge mclk) disable iff (!nrst) plainReceive);
  bad_addr_c: cover property (@(posedge mclk) disable iff (!nrst)
    avsResponse == RSTC_RESP_SLVERR && !avsWaitRequest && request);
endmodule : rstc_top

/* test/rstc_far_model.sv */
`timescale 1ns/1ps
// far side: analog front end and secure module, changing just after clock edges
module rstc_far_model (
  input wire logic mclk,
  input wire logic nrst,
  output logic bitClkTick,
  output logic secureModuleInputPin,
  output logic analogModulation,
  output logic antennaRxPin
);
  logic [4:0] cnt_q;
  // free counter paces the bit clock and the pin patterns
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) cnt_q <= 5'h00;
    else cnt_q <= cnt_q + 5'h01;
  end
  // one bit clock every fourth cycle; pins differ so a wrong source shows
  assign bitClkTick = (cnt_q[1:0] == 2'h3);
  assign secureModuleInputPin = cnt_q[2];
  assign analogModulation = ~cnt_q[3];
  assign antennaRxPin = cnt_q[0]; // busy line, also during guard time
endmodule : rstc_far_model

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import rstc_pkg::*;
  logic mclk, nrst, avsRead, avsWrite, cmdStart, cmdStop, activeMode, txLastModPulse;
  logic rfFieldOn, avsWaitRequest, bitClkTick, secureModuleInputPin, analogModulation;
  logic antennaRxPin, uartInput, sigInIsModulation, rxEnable, rxDecoderData;
  logic decodeValid, bitCollision;
  logic [7:0] avsAddress, decodeStrength, halfBitStrong, halfBitWeak;
  logic [31:0] avsWriteData, avsReadData, rdat;
  logic [3:0] avsByteEnable, cmdCode;
  logic [1:0] avsResponse, resp;
  int error_cnt = 0;
  int tests_run = 0;
  rstc_top u_rstc_top (.mclk(mclk), .nrst(nrst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsResponse(avsResponse), .avsWaitRequest(avsWaitRequest),
    .cmdStart(cmdStart), .cmdCode(cmdCode), .cmdStop(cmdStop), .activeMode(activeMode),
    .bitClkTick(bitClkTick), .txLastModPulse(txLastModPulse), .rfFieldOn(rfFieldOn),
    .secureModuleInputPin(secureModuleInputPin), .analogModulation(analogModulation),
    .antennaRxPin(antennaRxPin), .decodeStrength(decodeStrength),
    .halfBitStrong(halfBitStrong), .halfBitWeak(halfBitWeak), .uartInput(uartInput),
    .sigInIsModulation(sigInIsModulation), .rxEnable(rxEnable),
    .rxDecoderData(rxDecoderData), .decodeValid(decodeValid), .bitCollision(bitCollision));
  rstc_far_model u_rstc_far_model (.mclk(mclk), .nrst(nrst), .bitClkTick(bitClkTick),
    .secureModuleInputPin(secureModuleInputPin), .analogModulation(analogModulation),
    .antennaRxPin(antennaRxPin));
  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // compare one result, count it, report a difference
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one avalon access, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [7:0] dat);
    logic ok;
    ok = 1'b0;
    @(posedge mclk);
    avsAddress <= adr;
    avsWriteData <= {24'h000000, dat};
    avsRead <= ~wr;
    avsWrite <= wr;
    while (!ok) begin
      #1 ok = (avsWaitRequest === 1'b0);
      @(posedge mclk);
    end
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    #1 rdat = avsReadData;
    resp = avsResponse;
  endtask : bus
  // reset values, reserved bit, unmapped address
  task automatic t_regs;
    bus(1'b0, RSTC_ADDR_SOURCE, 8'h00);
    chk(rdat, 32'h00000084);
    chk(resp, RSTC_RESP_OKAY);
    bus(1'b0, RSTC_ADDR_THRESH, 8'h00);
    chk(rdat, 32'h00000084);
    bus(1'b1, RSTC_ADDR_THRESH, 8'hff);
    bus(1'b0, RSTC_ADDR_THRESH, 8'h00);
    chk(rdat, 32'h000000f7);
    bus(1'b1, 8'h10, 8'h55);
    chk(resp, RSTC_RESP_SLVERR);
    bus(1'b0, 8'h10, 8'h00);
    chk(rdat, 32'h00000000);
  endtask : t_regs
  // every source select, uart input one cycle behind the chosen pin
  task automatic t_source;
    logic s, a;
    logic [1:0] sel;
    for (int i = 0; i < 4; i++) begin
      sel = i[1:0];
      bus(1'b1, RSTC_ADDR_SOURCE, {sel, 6'h05});
      bus(1'b0, RSTC_ADDR_SOURCE, 8'h00);
      chk(rdat, {24'h000000, sel, 6'h05});
      @(posedge mclk);
      repeat (8) begin
        #1 s = secureModuleInputPin;
        a = analogModulation;
        @(posedge mclk);
        #1 chk(uartInput, (sel == 2'h0) ? 1'b0 : (sel == 2'h2) ? a : s);
        chk(sigInIsModulation, (sel == 2'h3));
      end
    end
  endtask : t_source
  // command, start event, guard count in bit clocks, then stop
  task automatic t_guard(input logic act, input logic [3:0] code, input logic [5:0] n);
    int ticks;
    ticks = 0;
    bus(1'b1, RSTC_ADDR_SOURCE, {2'h2, n});
    activeMode <= act;
    @(posedge mclk);
    cmdStart <= 1'b1;
    cmdCode <= code;
    @(posedge mclk);
    cmdStart <= 1'b0;
    if (code != RSTC_CMD_RECEIVE) begin
      @(posedge mclk);
      txLastModPulse <= ~act;
      rfFieldOn <= act;
      #1 chk(rxEnable, 1'b0);
      @(posedge mclk);
      txLastModPulse <= 1'b0;
      rfFieldOn <= 1'b0;
      // count the ticks that the next edges sample; exit at the edge of the last one
      while (ticks < int'(n)) begin
        #1 chk(rxEnable, 1'b0);
        chk(rxDecoderData, 1'b0);
        chk(decodeValid, 1'b0);
        ticks += int'(bitClkTick);
        @(posedge mclk);
      end
    end
    #1 chk(rxEnable, 1'b1);
    @(posedge mclk);
    cmdStop <= 1'b1;
    @(posedge mclk);
    cmdStop <= 1'b0;
    #1 chk(rxEnable, 1'b0);
  endtask : t_guard
  // one strength sample against the decode and collision levels
  task automatic lvl(input logic [7:0] s, input logic [7:0] w, input logic v, input logic c);
    @(posedge mclk);
    decodeStrength <= s;
    halfBitWeak <= w;
    @(posedge mclk);
    #1 chk(decodeValid, v);
    chk(bitCollision, c);
  endtask : lvl
  // verdict and end of run
  task automatic end_of_test;
    $display("errors %0d compares %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // the run needs under 2000 cycles; cut a hang at 4000
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
  // reset, then the scenarios in turn
  initial begin
    nrst = 1'b0;
    avsAddress = 8'h00;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWriteData = 32'h00000000;
    avsByteEnable = 4'hf;
    cmdStart = 1'b0;
    cmdCode = 4'h0;
    cmdStop = 1'b0;
    activeMode = 1'b0;
    txLastModPulse = 1'b0;
    rfFieldOn = 1'b0;
    decodeStrength = 8'h00;
    halfBitStrong = 8'h10;
    halfBitWeak = 8'h00;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_source();
    t_guard(1'b0, 4'hc, 6'h03);
    t_guard(1'b1, 4'h1, 6'h02);
    t_guard(1'b0, 4'h3, 6'h3f);
    t_guard(1'b0, 4'h5, 6'h00);
    t_guard(1'b0, RSTC_CMD_RECEIVE, 6'h05);
    bus(1'b1, RSTC_ADDR_THRESH, 8'h44);
    @(posedge mclk);
    cmdStart <= 1'b1;
    cmdCode <= RSTC_CMD_RECEIVE;
    @(posedge mclk);
    cmdStart <= 1'b0;
    lvl(8'h03, 8'h08, 1'b0, 1'b0);
    lvl(8'h04, 8'h08, 1'b1, 1'b1);
    lvl(8'h04, 8'h07, 1'b1, 1'b0);
    end_of_test();
  end
endmodule : tb_top
